// file: iodl_pkg.sv
/*
 * Shared constants and types for the I/O delay and master phase loop block.
 * Assumes a single 20 MHz system clock; delays are modelled as step codes.
 */
package iodl_pkg;

	// Delay profiles; user_profile is the reset choice
	typedef enum logic [3:0] {
		IODL_USER,
		IODL_SCLK_ZEROHOLD,
		IODL_ECLK_ALIGNED,
		IODL_ECLK_CENTERED,
		IODL_SCLK_ALIGNED,
		IODL_SCLK_CENTERED,
		IODL_CMD_CLK,
		IODL_DQS_ALIGNED_X2,
		IODL_DQS_ALIGNED_X4,
		IODL_DQS_CENTERED_X2,
		IODL_DQS_CENTERED_X4
	} iodl_profile_t;

	// Coarse codes: none, 800 ps, 1600 ps, illegal
	typedef enum logic [1:0] {
		IODL_C0,
		IODL_C800,
		IODL_C1600,
		IODL_CBAD
	} iodl_coarse_t;

	// Step sizes and their ratio
	localparam int COARSE_STEP_PS = 800;
	localparam int FINE_STEP_FS = 12500;
	localparam int COARSE_UNITS = COARSE_STEP_PS * 1000 / FINE_STEP_FS;

	// Fine counter range and reset values
	localparam logic [6:0] FINE_MIN = 7'h00;
	localparam logic [6:0] FINE_MAX = 7'h7f;
	localparam logic [6:0] FINE_RST = 7'h00;
	localparam logic [1:0] COARSE_RST = 2'h0;

	// Factory fine values per profile family
	localparam logic [6:0] FAC_ZEROHOLD = 7'h20;
	localparam logic [6:0] FAC_ALIGNED = 7'h00;
	localparam logic [6:0] FAC_CENTERED = 7'h28;
	localparam logic [6:0] FAC_CMD_CLK = 7'h10;

	// Phase loop codes and lock qualification
	localparam logic [7:0] CODE_RST = 8'h00;
	localparam logic [7:0] CODE_MAX = 8'hff;
	localparam logic [9:0] PER_MAX = 10'h3ff;
	localparam logic [2:0] LOCK_HITS = 3'h4;

	// Fine value applied after configuration or restore
	function automatic logic [6:0] iodl_default_fine(iodl_profile_t p, logic [6:0] user);
		logic [6:0] v;
		v = user;
		case (p)
			IODL_USER: v = user;
			IODL_SCLK_ZEROHOLD: v = FAC_ZEROHOLD;
			IODL_CMD_CLK: v = FAC_CMD_CLK;
			IODL_ECLK_CENTERED,
			IODL_SCLK_CENTERED,
			IODL_DQS_CENTERED_X2,
			IODL_DQS_CENTERED_X4: v = FAC_CENTERED;
			default: v = FAC_ALIGNED;
		endcase
		return v;
	endfunction

endpackage

// file: iodl_static_cell.sv
/*
 * Static delay cell: fixed fine delay code plus a retimed data path.
 * Assumes configuration inputs are steady around reset release.
 */
`timescale 1ns/1ps
module iodl_static_cell import iodl_pkg::*; (
	// Clock, reset, enable
	input logic clk,
	input logic rst,
	input logic ce,
	// Configuration
	input iodl_profile_t delay_profile,
	input logic [6:0] fine_delay_setting,
	// Pin
	input logic data_pin,
	// Results
	output logic [6:0] static_fine_code,
	output logic static_data_out
);

	logic [1:0] data_sync;
	logic [6:0] next_code;
	logic next_out;

	// Code is frozen; there is deliberately no step input
	always_comb begin
		next_code = static_fine_code;
		next_out = data_sync[1];
	end

	// Value captured only while reset is held
	always_ff @(posedge clk) begin
		if (rst) begin
			static_fine_code <= iodl_default_fine(delay_profile, fine_delay_setting);
			static_data_out <= 1'b0;
			data_sync <= 2'h0;
		end else if (ce) begin
			static_fine_code <= next_code;
			static_data_out <= next_out;
			data_sync <= {data_sync[0], data_pin};
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_static_fixed: assert property (1'b1 |=> $stable(static_fine_code))
		else $error("static delay code changed after reset");

endmodule

// file: iodl_phase_loop.sv
/*
 * Master phase loop: quarter-period delay code, lock flag, update gate.
 * Assumes the reference clock is far slower than clk and arrives on a pin.
 */
`timescale 1ns/1ps
module iodl_phase_loop import iodl_pkg::*; (
	// Clock, reset, enable
	input logic clk,
	input logic rst,
	input logic ce,
	// Loop controls
	input logic loop_rst,
	input logic ref_clk_pin,
	input logic ref_clock_hold,
	input logic max_delay_bypass,
	input logic code_update_n,
	// Results
	output logic [7:0] phase_codes,
	output logic [7:0] phase_code_tap,
	output logic phase_lock
);

	typedef enum logic [1:0] {LP_MEASURE, LP_LOCKED, LP_FORCED} iodl_loop_state_t;

	iodl_loop_state_t state, next_state;
	logic [1:0] ref_sync;
	logic ref_q, next_ref_q, rise;
	logic [9:0] per, next_per;
	logic [7:0] tgt, next_tap, next_codes;
	logic [2:0] hits, next_hits;
	logic next_lock;

	// Period tracking and lock decision
	always_comb begin
		rise = ref_sync[1] & ~ref_q & ~ref_clock_hold;
		tgt = per[9:2];
		next_state = state;
		next_ref_q = ref_sync[1];
		next_per = (per == PER_MAX) ? per : per + 10'h001;
		next_tap = phase_code_tap;
		next_hits = hits;
		next_lock = phase_lock;
		next_codes = code_update_n ? phase_codes : phase_code_tap;
		if (loop_rst) begin
			next_state = LP_MEASURE;
			next_tap = CODE_RST;
			next_hits = 3'h0;
			next_lock = 1'b0;
			next_codes = CODE_RST;
		end else begin
			unique case (state)
				LP_FORCED: begin
					next_tap = CODE_MAX;
				end
				LP_MEASURE,
				LP_LOCKED: begin
					if (max_delay_bypass) begin
						next_state = LP_FORCED;
						next_tap = CODE_MAX;
						next_lock = 1'b1;
					end else if (rise) begin
						next_per = 10'h001;
						if (phase_code_tap < tgt) begin
							next_tap = phase_code_tap + 8'h01;
							next_hits = 3'h0;
						end else if (phase_code_tap > tgt) begin
							next_tap = phase_code_tap - 8'h01;
							next_hits = 3'h0;
						end else if (hits != LOCK_HITS) begin
							next_hits = hits + 3'h1;
						end
						// Lock only after the code has settled
						if (state == LP_MEASURE && hits == LOCK_HITS - 3'h1 &&
							phase_code_tap == tgt) begin
							next_state = LP_LOCKED;
							next_lock = 1'b1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= LP_MEASURE;
			ref_sync <= 2'h0;
			ref_q <= 1'b0;
			per <= 10'h000;
			phase_code_tap <= CODE_RST;
			phase_codes <= CODE_RST;
			hits <= 3'h0;
			phase_lock <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			ref_sync <= {ref_sync[0], ref_clk_pin};
			ref_q <= next_ref_q;
			per <= next_per;
			phase_code_tap <= next_tap;
			phase_codes <= next_codes;
			hits <= next_hits;
			phase_lock <= next_lock;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_lock_reset: assert property (ce && loop_rst |=> !phase_lock)
		else $error("lock seen during loop reset");
	chk_bypass_max: assert property (ce && max_delay_bypass && !loop_rst
		|=> phase_lock && phase_code_tap == CODE_MAX)
		else $error("bypass did not lock at maximum code");
	chk_update_freeze: assert property (ce && code_update_n && !loop_rst
		|=> $stable(phase_codes))
		else $error("phase codes moved without update");
	chk_update_copy: assert property (ce && !code_update_n && !loop_rst
		|=> phase_codes == $past(phase_code_tap))
		else $error("phase codes not taken from tap");
	chk_hold_gate: assert property (ce && ref_clock_hold && !loop_rst && !max_delay_bypass
		|=> $stable(phase_code_tap))
		else $error("code moved while reference held");
	chk_lock_valid: assert property ($rose(phase_lock) && state == LP_LOCKED
		|-> $past(hits) == LOCK_HITS - 3'h1)
		else $error("lock raised before code settled");
	cov_loop_locks: cover property (state == LP_MEASURE ##1 state == LP_LOCKED);

endmodule

// file: iodl_top.sv
/*
 * Top of the I/O delay block: dynamic delay cell logic, plus the static
 * delay cell and the master phase loop as submodules.
 * Assumes step, direction, restore and coarse come from fabric logic on clk;
 * data and reference clock arrive on pins and are synchronised here.
 */
`timescale 1ns/1ps
module iodl_top import iodl_pkg::*; (
	// Clock, reset, enable
	input logic clk,
	input logic rst,
	input logic ce,
	// Dynamic cell configuration
	input iodl_profile_t delay_profile,
	input logic [6:0] fine_delay_setting,
	input logic big_step_source,
	input iodl_coarse_t big_step_static,
	input logic transition_watch_en,
	// Dynamic cell fabric controls
	input logic delay_restore_n,
	input logic step_pulse,
	input logic step_dir,
	input iodl_coarse_t coarse_in,
	// Data pins
	input logic data_pin,
	input logic static_data_pin,
	// Static cell configuration
	input iodl_profile_t static_profile,
	input logic [6:0] static_fine_setting,
	// Phase loop controls
	input logic ref_clk_pin,
	input logic loop_rst,
	input logic ref_clock_hold,
	input logic max_delay_bypass,
	input logic code_update_n,
	// Dynamic cell results
	output logic dyn_data_out,
	output logic [6:0] dyn_fine_code,
	output iodl_coarse_t dyn_coarse_code,
	output logic [7:0] dyn_total_steps,
	output logic edge_error,
	output logic limit_reached,
	// Static cell results
	output logic [6:0] static_fine_code,
	output logic static_data_out,
	// Phase loop results
	output logic [7:0] phase_codes,
	output logic [7:0] phase_code_tap,
	output logic phase_lock
);

	// Data pin synchroniser and edge history
	logic [1:0] data_sync;
	logic data_q;

	// Step edge detection
	logic step_prev;
	logic step;

	// Next values
	logic [6:0] dflt;
	logic [6:0] next_fine;
	iodl_coarse_t next_coarse;
	iodl_coarse_t coarse_src;
	logic [7:0] next_total;
	logic next_limit;
	logic next_err;
	logic next_out;
	logic edge_seen;

	// Fine counter, flags and coarse selection
	always_comb begin
		step = step_prev & ~step_pulse;
		dflt = iodl_default_fine(delay_profile, fine_delay_setting);
		edge_seen = data_sync[1] ^ data_q;
		coarse_src = big_step_source ? coarse_in : big_step_static;
		next_fine = dyn_fine_code;
		next_limit = limit_reached;
		next_err = edge_error;
		next_coarse = dyn_coarse_code;
		next_out = data_sync[1];

		if (!delay_restore_n) begin
			// Restore wins over a step in the same cycle
			next_fine = dflt;
			next_limit = 1'b0;
			next_err = 1'b0;
		end else if (step) begin
			if (step_dir) begin
				if (dyn_fine_code == FINE_MIN) begin
					next_limit = 1'b1;
				end else begin
					next_fine = dyn_fine_code - 7'h01;
					next_limit = 1'b0;
				end
			end else begin
				if (dyn_fine_code == FINE_MAX) begin
					next_limit = 1'b1;
				end else begin
					next_fine = dyn_fine_code + 7'h01;
					next_limit = 1'b0;
				end
			end
		end

		// A data edge meeting a step means the window moved onto it;
		// placed after the restore so a new error is never lost
		if (transition_watch_en && step && edge_seen) begin
			next_err = 1'b1;
		end

		// Illegal coarse code keeps the last legal one
		if (coarse_src != IODL_CBAD) begin
			next_coarse = coarse_src;
		end

		// Total in fine units; 64 fine steps make one coarse step
		next_total = 8'(int'(next_coarse) * COARSE_UNITS + int'(next_fine));
	end

	// Register stage; reset applies the profile default
	always_ff @(posedge clk) begin
		if (rst) begin
			data_sync <= 2'h0;
			data_q <= 1'b0;
			step_prev <= 1'b0;
			dyn_fine_code <= iodl_default_fine(delay_profile, fine_delay_setting);
			dyn_coarse_code <= iodl_coarse_t'(COARSE_RST);
			dyn_total_steps <= 8'h00;
			edge_error <= 1'b0;
			limit_reached <= 1'b0;
			dyn_data_out <= 1'b0;
		end else if (ce) begin
			data_sync <= {data_sync[0], data_pin};
			data_q <= data_sync[1];
			step_prev <= step_pulse;
			dyn_fine_code <= next_fine;
			dyn_coarse_code <= next_coarse;
			dyn_total_steps <= next_total;
			edge_error <= next_err;
			limit_reached <= next_limit;
			dyn_data_out <= next_out;
		end
	end

	// Static cell has its own pin and no step controls
	iodl_static_cell u_static (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.delay_profile(static_profile),
		.fine_delay_setting(static_fine_setting),
		.data_pin(static_data_pin),
		.static_fine_code(static_fine_code),
		.static_data_out(static_data_out)
	);

	// Master phase loop
	iodl_phase_loop u_loop (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.loop_rst(loop_rst),
		.ref_clk_pin(ref_clk_pin),
		.ref_clock_hold(ref_clock_hold),
		.max_delay_bypass(max_delay_bypass),
		.code_update_n(code_update_n),
		.phase_codes(phase_codes),
		.phase_code_tap(phase_code_tap),
		.phase_lock(phase_lock)
	);

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_restore_default: assert property (ce && !delay_restore_n
		|=> dyn_fine_code == $past(dflt))
		else $error("restore did not reload default");
	chk_step_up: assert property (ce && delay_restore_n && step && !step_dir &&
		dyn_fine_code != FINE_MAX |=> dyn_fine_code == $past(dyn_fine_code) + 7'h01)
		else $error("increase step wrong");
	chk_step_down: assert property (ce && delay_restore_n && step && step_dir &&
		dyn_fine_code != FINE_MIN |=> dyn_fine_code == $past(dyn_fine_code) - 7'h01)
		else $error("decrease step wrong");
	chk_step_edge: assert property (ce && delay_restore_n && !step_prev
		|=> $stable(dyn_fine_code))
		else $error("fine code moved without falling step edge");
	chk_limit_top: assert property (ce && delay_restore_n && step && !step_dir &&
		dyn_fine_code == FINE_MAX |=> limit_reached && dyn_fine_code == FINE_MAX)
		else $error("upper limit not flagged");
	chk_limit_bottom: assert property (ce && delay_restore_n && step && step_dir &&
		dyn_fine_code == FINE_MIN |=> limit_reached && dyn_fine_code == FINE_MIN)
		else $error("lower limit not flagged");
	chk_coarse_bad: assert property (ce && coarse_src == IODL_CBAD
		|=> $stable(dyn_coarse_code))
		else $error("illegal coarse code applied");
	chk_coarse_source: assert property (ce && coarse_src != IODL_CBAD
		|=> dyn_coarse_code == $past(coarse_src))
		else $error("coarse code not from selected source");
	chk_edge_flag: assert property (ce && transition_watch_en && step && edge_seen
		|=> edge_error)
		else $error("edge error not raised");
	chk_monitor_off: assert property (!transition_watch_en && !edge_error
		|=> !edge_error)
		else $error("edge error while monitor disabled");
	chk_total_sum: assert property (ce |=> dyn_total_steps ==
		8'(int'(dyn_coarse_code) * COARSE_UNITS + int'(dyn_fine_code)))
		else $error("total delay steps mismatch");

	// Restore clears both flags; only a fresh edge error in that cycle survives
	chk_restore_limit: assert property (ce && !delay_restore_n |=> !limit_reached)
		else $error("limit flag survived restore");
	chk_restore_err: assert property (ce && !delay_restore_n &&
		!(transition_watch_en && step && edge_seen) |=> !edge_error)
		else $error("edge error survived restore");

	// A step is one cycle wide and nothing but a step or a restore moves the counter
	chk_fine_idle: assert property (ce && delay_restore_n && !step
		|=> $stable(dyn_fine_code))
		else $error("fine code moved without a step");
	chk_step_once: assert property (ce && step |=> !step)
		else $error("one pulse gave more than one step");

	// Limit flag follows the last step only
	chk_limit_clear_up: assert property (ce && delay_restore_n && step && !step_dir &&
		dyn_fine_code != FINE_MAX |=> !limit_reached)
		else $error("limit flag kept after legal increase");
	chk_limit_clear_down: assert property (ce && delay_restore_n && step && step_dir &&
		dyn_fine_code != FINE_MIN |=> !limit_reached)
		else $error("limit flag kept after legal decrease");
	chk_limit_hold: assert property (ce && delay_restore_n && !step
		|=> $stable(limit_reached))
		else $error("limit flag moved without a step");

	// Edge error is sticky and has one cause only
	chk_err_sticky: assert property (ce && delay_restore_n && edge_error |=> edge_error)
		else $error("edge error dropped without restore");
	chk_err_cause: assert property (ce && !edge_error &&
		!(transition_watch_en && step && edge_seen) |=> !edge_error)
		else $error("edge error raised without cause");

	// Each coarse source reaches the applied code; the illegal code never does
	chk_coarse_static: assert property (ce && !big_step_source &&
		big_step_static != IODL_CBAD |=> dyn_coarse_code == $past(big_step_static))
		else $error("static coarse choice not applied");
	chk_coarse_dyn: assert property (ce && big_step_source &&
		coarse_in != IODL_CBAD |=> dyn_coarse_code == $past(coarse_in))
		else $error("fabric coarse code not applied");
	chk_coarse_legal: assert property (dyn_coarse_code != IODL_CBAD)
		else $error("illegal coarse code applied");

	// Data path latency and clock-enable freeze
	chk_data_delay: assert property (ce |=> dyn_data_out == $past(data_sync[1]))
		else $error("data path latency wrong");
	chk_ce_freeze: assert property (!ce |=> $stable(dyn_fine_code) &&
		$stable(dyn_coarse_code) && $stable(edge_error) &&
		$stable(limit_reached))
		else $error("state moved while clock enable low");

	cov_hit_top: cover property (ce && step && !step_dir && dyn_fine_code == FINE_MAX);
	cov_edge_err: cover property ($rose(edge_error));
	cov_restore_after_step: cover property (step ##[1:20] !delay_restore_n);
	cov_hit_bottom: cover property (ce && step && step_dir && dyn_fine_code == FINE_MIN);

endmodule

// file: iodl_fabric.sv
/*
 * Partner model of the user fabric logic: step, restore, coarse, data pin.
 * Assumes it shares clk with iodl_top and changes outputs after rising edges.
 */
`timescale 1ns/1ps
module iodl_fabric import iodl_pkg::*; (
	// Clock
	input logic clk,
	// Fabric controls
	output logic step_pulse,
	output logic step_dir,
	output logic delay_restore_n,
	output iodl_coarse_t coarse_in,
	// Pin; this cell delays the input path only, never the output too
	output logic data_pin
);
	logic toggle;
	// Idle levels from time zero
	initial begin
		step_pulse = 1'b0;
		step_dir = 1'b0;
		delay_restore_n = 1'b1;
		coarse_in = IODL_C0;
		data_pin = 1'b0;
		toggle = 1'b0;
	end
	// While toggle is set the pin flips every cycle, so any step meets a data edge
	always @(posedge clk) begin
		if (toggle) begin
			data_pin <= ~data_pin;
		end
	end
	// Pulse high one cycle then low; direction held past the falling edge
	task automatic step(input logic d);
		@(posedge clk);
		step_pulse <= 1'b1;
		step_dir <= d;
		@(posedge clk);
		step_pulse <= 1'b0;
		@(posedge clk);
	endtask
	// Restore held low for one sampled edge
	task automatic restore();
		@(posedge clk);
		delay_restore_n <= 1'b0;
		@(posedge clk);
		delay_restore_n <= 1'b1;
	endtask
	// The illegal code is never put on the wire
	task automatic set_coarse(input iodl_coarse_t c);
		if (c != IODL_CBAD) begin
			coarse_in <= c;
		end
	endtask
	task automatic set_toggle(input logic b);
		toggle <= b;
	endtask
endmodule

// file: iodl_top_bench.sv
/*
 * Self-checking bench for iodl_top: profiles, steps, limits, coarse, monitor, loop.
 * Assumes iodl_fabric drives fabric controls; expectations queued, checked at negedge.
 */
`timescale 1ns/1ps
`define CMP(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR %0t: output %0d got %h want %h", $time, n.sel, a, e); end end
module iodl_top_bench import iodl_pkg::*;;
	logic clk, rst, ce, big_step_source, transition_watch_en, static_data_pin, ref_clk_pin;
	logic loop_rst, ref_clock_hold, max_delay_bypass, code_update_n;
	iodl_profile_t delay_profile, static_profile;
	iodl_coarse_t big_step_static, coarse_in, dyn_coarse_code;
	logic [6:0] fine_delay_setting, static_fine_setting, dyn_fine_code, static_fine_code;
	logic step_pulse, step_dir, delay_restore_n, data_pin, dyn_data_out, static_data_out;
	logic [7:0] dyn_total_steps, phase_codes, phase_code_tap;
	logic edge_error, limit_reached, phase_lock;
	int err_total, num_checks;
	logic [31:0] seed;
	typedef struct {int sel; logic [15:0] val;} iodl_note_t;
	iodl_note_t notes[$];
	iodl_note_t n;
	logic [15:0] act;
	logic [2:0] spin_hist, dpin_hist;

	iodl_top i_iodl_top (.clk, .rst, .ce, .delay_profile, .fine_delay_setting,
		.big_step_source, .big_step_static, .transition_watch_en, .delay_restore_n,
		.step_pulse, .step_dir, .coarse_in, .data_pin, .static_data_pin, .static_profile,
		.static_fine_setting, .ref_clk_pin, .loop_rst, .ref_clock_hold, .max_delay_bypass,
		.code_update_n, .dyn_data_out, .dyn_fine_code, .dyn_coarse_code, .dyn_total_steps,
		.edge_error, .limit_reached, .static_fine_code, .static_data_out, .phase_codes,
		.phase_code_tap, .phase_lock);
	iodl_fabric i_iodl_fabric (.clk, .step_pulse, .step_dir, .delay_restore_n, .coarse_in,
		.data_pin);

	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Fine value each profile should start from
	function automatic logic [6:0] dflt(iodl_profile_t p, logic [6:0] u);
		case (p)
			IODL_USER: return u;
			IODL_SCLK_ZEROHOLD: return FAC_ZEROHOLD;
			IODL_CMD_CLK: return FAC_CMD_CLK;
			IODL_ECLK_CENTERED, IODL_SCLK_CENTERED, IODL_DQS_CENTERED_X2,
			IODL_DQS_CENTERED_X4: return FAC_CENTERED;
			default: return FAC_ALIGNED;
		endcase
	endfunction
	task automatic note(input int s, input logic [15:0] v);
		notes.push_back('{s, v});
	endtask
	task automatic done(input string s);
		@(negedge clk);
		$display("test %s finished", s);
		@(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Oldest notes checked once the outputs have settled
	always @(negedge clk) begin
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.sel)
				0: act = {9'h0, dyn_fine_code};
				1: act = {14'h0, dyn_coarse_code};
				2: act = {8'h0, dyn_total_steps};
				3: act = {15'h0, edge_error};
				4: act = {15'h0, limit_reached};
				5: act = {9'h0, static_fine_code};
				6: act = {8'h0, phase_code_tap};
				7: act = {8'h0, phase_codes};
				9: act = {15'h0, dyn_data_out};
				10: act = {15'h0, static_data_out};
				default: act = {15'h0, phase_lock};
			endcase
			`CMP(act, n.val) // as tagged on each note
		end
	end

	// Random pin noise on the static path
	always @(posedge clk) begin
		static_data_pin <= 1'(xs());
		spin_hist <= {spin_hist[1:0], static_data_pin};
		dpin_hist <= {dpin_hist[1:0], data_pin};
	end

	task automatic do_reset(input iodl_profile_t p, input logic [6:0] u, input int c);
		delay_profile <= p;
		fine_delay_setting <= u;
		static_profile <= p; // Static cell gets the same profile as the dynamic cell
		static_fine_setting <= ~u;
		rst <= 1'b1;
		repeat (c) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		note(0, dflt(p, u));
		note(5, dflt(p, ~u));
		note(4, 16'h0);
	endtask
	// One step, coarse held at zero so total equals fine
	task automatic stp(input logic d, input logic [6:0] f, input logic lim);
		i_iodl_fabric.step(d);
		note(0, f);
		note(2, f);
		note(4, lim);
	endtask

	// Hang guard
	initial begin
		for (int i = 0; i < 20000; i++) @(posedge clk);
		err_total++;
		$display("ERROR %0t: run did not finish", $time);
		report_and_stop();
	end

	initial begin
		seed = 32'h2fc7;
		err_total = 0;
		num_checks = 0;
		{rst, ce, big_step_source, transition_watch_en} = 4'hc;
		{ref_clk_pin, loop_rst, ref_clock_hold, max_delay_bypass, code_update_n} = 5'h01;
		big_step_static = IODL_C0;
		do_reset(IODL_USER, 7'h00, 12);
		for (int p = 0; p <= 10; p++) begin
			do_reset(iodl_profile_t'(p), 7'(xs()), 2);
		end
		done("profiles");
		do_reset(IODL_USER, 7'h40, 2);
		stp(1'b0, 7'h41, 1'b0);
		stp(1'b1, 7'h40, 1'b0);
		stp(1'b1, 7'h3f, 1'b0);
		do_reset(IODL_USER, 7'h7f, 2);
		stp(1'b0, 7'h7f, 1'b1);
		stp(1'b1, 7'h7e, 1'b0);
		do_reset(IODL_USER, 7'h00, 2);
		stp(1'b1, 7'h00, 1'b1);
		done("steps");
		do_reset(IODL_USER, 7'h15, 2);
		stp(1'b0, 7'h16, 1'b0);
		stp(1'b0, 7'h17, 1'b0);
		i_iodl_fabric.restore();
		note(0, 16'h15);
		done("restore");
		for (int c = 0; c < 3; c++) begin
			i_iodl_fabric.set_coarse(iodl_coarse_t'(c));
			big_step_source <= 1'b1;
			big_step_static <= iodl_coarse_t'((c + 1) % 3);
			repeat (3) @(posedge clk);
			note(1, c);
			note(2, c * COARSE_UNITS + 16'h15);
			big_step_source <= 1'b0;
			big_step_static <= iodl_coarse_t'(c);
			i_iodl_fabric.set_coarse(iodl_coarse_t'((c + 2) % 3));
			repeat (3) @(posedge clk);
			note(1, c);
		end
		done("coarse");
		transition_watch_en <= 1'b0;
		i_iodl_fabric.set_toggle(1'b1);
		repeat (4) @(posedge clk);
		i_iodl_fabric.step(1'b0);
		@(posedge clk);
		note(3, 16'h0);
		transition_watch_en <= 1'b1;
		i_iodl_fabric.step(1'b0);
		@(posedge clk);
		note(3, 16'h1);
		// Both data paths: pin value three edges back
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			#1;
			note(9, dpin_hist[2]);
			note(10, spin_hist[2]);
		end
		@(posedge clk);
		i_iodl_fabric.set_toggle(1'b0);
		repeat (4) @(posedge clk);
		i_iodl_fabric.restore();
		note(3, 16'h0);
		note(0, 16'h15);
		done("edge monitor");
		// Clock enable low swallows a whole pulse
		ce <= 1'b0;
		i_iodl_fabric.step(1'b0);
		note(0, 16'h15);
		ce <= 1'b1;
		@(posedge clk);
		note(0, 16'h15);
		ref_clock_hold <= 1'b1;
		max_delay_bypass <= 1'b1;
		repeat (2) @(posedge clk);
		note(6, 16'hff);
		note(8, 16'h1);
		note(7, 16'h0);
		code_update_n <= 1'b0;
		repeat (3) @(posedge clk);
		note(7, 16'hff);
		loop_rst <= 1'b1;
		max_delay_bypass <= 1'b0;
		ref_clock_hold <= 1'b0;
		repeat (3) @(posedge clk);
		note(8, 16'h0);
		note(6, 16'h0);
		note(7, 16'h0);
		loop_rst <= 1'b0;
		repeat (4) @(posedge clk);
		note(8, 16'h0);
		// Held reference: edges arrive but the code must not move
		ref_clock_hold <= 1'b1;
		for (int k = 0; k < 64; k++) begin
			@(posedge clk);
			if (k % 8 == 7) begin
				ref_clk_pin <= ~ref_clk_pin;
			end
		end
		note(6, 16'h0);
		ref_clock_hold <= 1'b0;
		// Reference period 16 cycles, same as in the held run
		for (int k = 0; k < 224; k++) begin
			@(posedge clk);
			if (k % 8 == 7) begin
				ref_clk_pin <= ~ref_clk_pin;
			end
		end
		note(6, 16'h4);
		note(7, 16'h4);
		note(8, 16'h1);
		done("phase loop");
		repeat (2) @(negedge clk);
		report_and_stop();
	end
endmodule
